// File: ir_host.sv
// two-wire bus master that drives the infrared array, ordered over apb
//
// Function
// - device is target only; host alone generates the serial clock.
// - both lines are driven open-drain: pull low for zero, release for one.
// - data line changes only while clock is low, except start and stop.
// - session opens with start, closes with stop, both with clock high.
// - seven address bits then direction bit, high for read, low for write.
// - ninth clock is acknowledge: receiver pulls low, or leaves high for refusal.
// - measurement trigger is opcode 0x01 then 0x08.
// - read is opcode 0x02 then start address, step and word count.
// - host picks the readout pattern through start, step and count.
// - config write: opcode 0x03, each byte sent minus 0x55 then plain.
// - trim write: opcode 0x04, each byte sent minus 0xAA then plain.
// - array traffic at most 1 MHz clock, memory chip at most 400 kHz.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`include "ir_host_params.svh"

module ir_host #(
	parameter int STARTUP_CYCLES = `STARTUP_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial clock pin
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	// serial data pin
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	// ==========================================
	// declarations
	ir_host_pkg::state_t state_q;
	ir_host_pkg::cmd_t cmd_q;
	logic [23:0] arg_q;
	logic [15:0] div_q, div_cnt_q, word_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [2:0] idx_q;
	logic [8:0] rx_left_q;
	logic [7:0] shift_q, word_lo_q;
	logic [31:0] boot_cnt_q, prdata_q;
	logic rs_q, rx_q, rx_hi_q, valid_q, ack_bad_q, busy_q, done_q, nack_q, ready_q;
	logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, scl_oe_q, sda_oe_q, low_q;
	logic pready_q, pslverr_q;

	// ==========================================
	// apb decode
	wire acc = psel & penable & ~pready_q;
	wire fire = psel & penable & pready_q;
	wire hit_ctrl = paddr == `REG_CTRL;
	wire hit_arg = paddr == `REG_ARG;
	wire hit_stat = paddr == `REG_STAT;
	wire hit_rdata = paddr == `REG_RDATA;
	wire hit_div = paddr == `REG_DIV;
	wire hit = hit_ctrl | hit_arg | hit_stat | hit_rdata | hit_div;
	wire wr_ctrl = fire & pwrite & hit_ctrl;
	wire wr_arg = fire & pwrite & hit_arg & ~busy_q;
	wire wr_div = fire & pwrite & hit_div & ~busy_q;
	wire rd_word = fire & ~pwrite & hit_rdata;
	wire [2:0] go_op = pwdata[2:0];
	wire go = wr_ctrl & ~busy_q & ready_q & (go_op != 3'h0) & (go_op <= 3'h4);
	wire [4:0] stat = {ready_q, valid_q, nack_q, done_q, busy_q};
	wire [31:0] rd_mux = hit_ctrl ? {29'h0, cmd_q.op} :
		hit_arg ? {8'h00, arg_q} :
		hit_stat ? {27'h0, stat} :
		hit_rdata ? {16'h0000, word_q} :
		hit_div ? {16'h0000, div_q} : 32'h0;

	// answer one cycle into the access phase, error on unmapped offsets
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc & ~hit;
			prdata_q <= acc ? rd_mux : 32'h0;
		end
	end

	// software registers: argument word, and divider floored so scl stays at or below 1 MHz
	always_ff @(posedge core_clk) begin
		if (rst) begin
			arg_q <= `ARG_RESET;
			div_q <= `DIV_RESET;
		end else begin
			if (wr_arg)
				arg_q <= pwdata[23:0];
			if (wr_div)
				div_q <= (pwdata[15:0] < `DIV_MIN) ? `DIV_MIN : pwdata[15:0];
		end
	end
	// ==========================================
	// start-up wait: no session until the device has come out of reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			boot_cnt_q <= 32'h0;
			ready_q <= 1'b0;
		end else if (!ready_q) begin
			boot_cnt_q <= boot_cnt_q + 32'h1;
			ready_q <= boot_cnt_q >= 32'(STARTUP_CYCLES - 1);
		end
	end
	// ==========================================
	// pin synchronisers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{scl_s_q, scl_m_q} <= 2'h3;
			{sda_s_q, sda_m_q} <= 2'h3;
		end else begin
			{scl_s_q, scl_m_q} <= {scl_m_q, scl_i};
			{sda_s_q, sda_m_q} <= {sda_m_q, sda_i};
		end
	end

	// quarter-period tick from the divider
	always_ff @(posedge core_clk) begin
		if (rst || state_q == ir_host_pkg::st_idle)
			div_cnt_q <= 16'h0;
		else
			div_cnt_q <= (div_cnt_q == div_q) ? 16'h0 : div_cnt_q + 16'h1;
	end

	// ==========================================
	// phase advance; the released clock must read high before moving on
	wire tick = div_cnt_q == div_q;
	wire adv = tick & ((ph_q != 2'd1) | scl_s_q);
	wire in_bit = state_q == ir_host_pkg::st_bit;
	wire ack_slot = bit_q == 4'd8;
	wire last_rx = rx_left_q == 9'd1;
	wire is_meas = cmd_q.op == ir_host_pkg::op_meas;
	wire is_read = cmd_q.op == ir_host_pkg::op_read;
	wire [7:0] key = (cmd_q.op == ir_host_pkg::op_cfg) ? `CFG_KEY : `TRIM_KEY;
	wire [7:0] opc = is_read ? `OP_READ :
		(cmd_q.op == ir_host_pkg::op_cfg) ? `OP_CFG : `OP_TRIM;
	wire [7:0] lo = cmd_q.arg[7:0];
	wire [7:0] hi = cmd_q.arg[15:8];
	wire [2:0] last_tx = is_meas ? 3'd2 : 3'd5;

	// byte to send, chosen by its place in the session
	wire [7:0] tx_meas = (idx_q == 3'd1) ? `OP_MEAS_LO : `OP_MEAS_HI;
	wire [7:0] tx_read = (idx_q == 3'd1) ? `OP_READ :
		(idx_q == 3'd2) ? cmd_q.arg[7:0] :
		(idx_q == 3'd3) ? cmd_q.arg[15:8] :
		(idx_q == 3'd4) ? cmd_q.arg[23:16] : {`DEV_ADDR, 1'b1};
	wire [7:0] tx_pair = (idx_q == 3'd1) ? opc :
		(idx_q == 3'd2) ? 8'(lo - key) :
		(idx_q == 3'd3) ? lo :
		(idx_q == 3'd4) ? 8'(hi - key) : hi;
	wire [7:0] tx_byte = (idx_q == 3'd0) ? {`DEV_ADDR, 1'b0} :
		is_meas ? tx_meas : is_read ? tx_read : tx_pair;
	wire tx_bit = tx_byte[3'(4'd7 - bit_q)];

	// ==========================================
	// pin drive, worked out per state and phase, then registered
	wire scl_start = (ph_q == 2'd0) ? rs_q : (ph_q == 2'd3);
	wire scl_drv = (state_q == ir_host_pkg::st_start) ? scl_start :
		in_bit ? (ph_q == 2'd0) | (ph_q == 2'd3) :
		(state_q == ir_host_pkg::st_stop) ? (ph_q == 2'd0) :
		(state_q == ir_host_pkg::st_hold);
	wire sda_bit = rx_q ? (ack_slot & ~last_rx) : (~ack_slot & ~tx_bit);
	wire sda_drv = (state_q == ir_host_pkg::st_start) ? (ph_q >= 2'd2) :
		in_bit ? sda_bit :
		(state_q == ir_host_pkg::st_stop) ? (ph_q <= 2'd1) : 1'b0;

	// outputs only ever pull low; the high level comes from the pull-up
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			low_q <= 1'b0;
		end else begin
			scl_oe_q <= scl_drv;
			sda_oe_q <= sda_drv;
			low_q <= 1'b0;
		end
	end

	// ==========================================
	// end-of-byte decisions
	wire byte_end = adv & in_bit & ack_slot & (ph_q == 2'd3);
	wire word_set = byte_end & rx_q & rx_hi_q;
	wire tx_refused = ~rx_q & ack_bad_q;

	// received word waits for software; set wins over the read that clears it
	always_ff @(posedge core_clk) begin
		if (rst)
			valid_q <= 1'b0;
		else
			valid_q <= word_set | (valid_q & ~rd_word);
	end

	// ==========================================
	// link sequencer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ir_host_pkg::st_idle;
			cmd_q <= '{op: ir_host_pkg::op_none, arg: 24'h0};
			ph_q <= 2'd0;
			bit_q <= 4'd0;
			idx_q <= 3'd0;
			rs_q <= 1'b0;
			rx_q <= 1'b0;
			rx_hi_q <= 1'b0;
			rx_left_q <= 9'd0;
			shift_q <= 8'h00;
			word_lo_q <= 8'h00;
			word_q <= 16'h0000;
			ack_bad_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			unique case (state_q)
				ir_host_pkg::st_idle: begin
					if (go) begin
						cmd_q <= '{op: ir_host_pkg::op_t'(go_op), arg: arg_q};
						state_q <= ir_host_pkg::st_start;
						ph_q <= 2'd0;
						idx_q <= 3'd0;
						rs_q <= 1'b0;
						rx_q <= 1'b0;
						busy_q <= 1'b1;
						done_q <= 1'b0;
						nack_q <= 1'b0;
					end
				end
				ir_host_pkg::st_start: begin
					if (adv) begin
						ph_q <= ph_q + 2'd1;
						if (ph_q == 2'd3) begin
							state_q <= ir_host_pkg::st_bit;
							bit_q <= 4'd0;
						end
					end
				end
				ir_host_pkg::st_bit: begin
					if (adv) begin
						ph_q <= ph_q + 2'd1;
						if (ph_q == 2'd2) begin
							if (ack_slot)
								ack_bad_q <= sda_s_q;
							else
								shift_q <= {shift_q[6:0], sda_s_q};
						end
						if (ph_q == 2'd3 && !ack_slot)
							bit_q <= bit_q + 4'd1;
						if (byte_end) begin
							bit_q <= 4'd0;
							if (tx_refused) begin
								nack_q <= 1'b1;
								state_q <= ir_host_pkg::st_stop;
							end else if (rx_q) begin
								// low byte first, then high byte completes the word
								rx_hi_q <= ~rx_hi_q;
								rx_left_q <= rx_left_q - 9'd1;
								if (rx_hi_q)
									word_q <= {shift_q, word_lo_q};
								else
									word_lo_q <= shift_q;
								if (last_rx)
									state_q <= ir_host_pkg::st_stop;
								else if (rx_hi_q)
									state_q <= ir_host_pkg::st_hold;
							end else if (is_read && idx_q == 3'd4) begin
								// repeated start, then the read address
								idx_q <= 3'd5;
								rs_q <= 1'b1;
								state_q <= ir_host_pkg::st_start;
							end else if (is_read && idx_q == 3'd5) begin
								rx_q <= 1'b1;
								rx_hi_q <= 1'b0;
								rx_left_q <= {cmd_q.arg[23:16], 1'b0};
								if (cmd_q.arg[23:16] == 8'h00)
									state_q <= ir_host_pkg::st_stop;
							end else if (!is_read && idx_q == last_tx) begin
								state_q <= ir_host_pkg::st_stop;
							end else begin
								idx_q <= idx_q + 3'd1;
							end
						end
					end
				end
				ir_host_pkg::st_hold: begin
					// clock held low until software has taken the last word
					ph_q <= 2'd0;
					if (!valid_q)
						state_q <= ir_host_pkg::st_bit;
				end
				ir_host_pkg::st_stop: begin
					if (adv) begin
						ph_q <= ph_q + 2'd1;
						if (ph_q == 2'd3) begin
							state_q <= ir_host_pkg::st_idle;
							busy_q <= 1'b0;
							done_q <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// port drive
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign scl_o = low_q;
	assign scl_oe = scl_oe_q;
	assign sda_o = low_q;
	assign sda_oe = sda_oe_q;
endmodule

// File: ir_host_params.svh
// timing, offsets, field positions and protocol bytes of the array host controller
`ifndef IR_HOST_PARAMS_SVH
`define IR_HOST_PARAMS_SVH

// ==========================================
// register offsets on the apb side
`define REG_CTRL 8'h00
`define REG_ARG 8'h04
`define REG_STAT 8'h08
`define REG_RDATA 8'h0C
`define REG_DIV 8'h10

// ==========================================
// status field positions
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_NACK 2
`define STAT_WORD 3
`define STAT_READY 4

// ==========================================
// reset values and divider floor
`define DIV_RESET 16'h0007
`define DIV_MIN 16'h0006 // floor: four quarters of seven cycles keep scl at or below 1 MHz
`define ARG_RESET 24'h000000

// ==========================================
// link bytes
`define DEV_ADDR 7'h60
`define OP_MEAS_LO 8'h01
`define OP_MEAS_HI 8'h08
`define OP_READ 8'h02
`define OP_CFG 8'h03
`define OP_TRIM 8'h04
`define CFG_KEY 8'h55
`define TRIM_KEY 8'hAA

// ==========================================
// start-up wait after reset
`define CLK_MHZ 25
`define STARTUP_MS 5
`define STARTUP_CYC (`STARTUP_MS * 1000 * `CLK_MHZ)

`endif

// File: ir_host_pkg.sv
// types shared by the array host controller
package ir_host_pkg;
	// ==========================================
	// command kinds that software may order
	typedef enum logic [2:0] {op_none, op_meas, op_read, op_cfg, op_trim} op_t;

	// ==========================================
	// a latched command: kind plus its argument word
	typedef struct packed {
		op_t op;
		logic [23:0] arg;
	} cmd_t;

	// ==========================================
	// link sequencer states
	typedef enum logic [2:0] {st_idle, st_start, st_bit, st_stop, st_hold} state_t;
endpackage

// File: ir_host_properties.sv
// assertions on the ports of the array host controller
`timescale 1ns/1ns
module ir_host_checker #(
	parameter int STARTUP_CYCLES = 125000
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	localparam logic [6:0] ADDR = 7'h60;
	logic scl_q, sda_q, first_q;
	logic [3:0] bit_q;
	int unsigned up_q;
	// ==========================================
	// link tracking
	// start, clock rise and mapped offsets
	wire start_w = scl_i && scl_q && sda_q && !sda_i;
	wire rise_w = scl_i && !scl_q;
	wire map_w = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	// time since reset and bit position in the byte
	always_ff @(posedge core_clk) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (rst) begin
			up_q <= 0;
			bit_q <= 4'h0;
			first_q <= 1'h0;
		end else if (start_w) begin
			bit_q <= 4'h0;
			first_q <= 1'h1;
		end else if (rise_w) begin
			bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
			first_q <= first_q && (bit_q != 4'h9);
		end
		if (!rst && up_q < STARTUP_CYCLES)
			up_q <= up_q + 1;
	end
	// ==========================================
	// properties
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence access_s;
		psel && penable && !pready;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	apb_answer_a: assert property (access_s |=> answer_s)
		else $error("bad apb answer");
	err_decode_a: assert property (psel && penable && !pready && !map_w |=> pslverr)
		else $error("no error on unmapped");
	err_mapped_a: assert property (psel && penable && !pready && map_w |=> !pslverr)
		else $error("error on mapped");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("stray read data");
	open_drain_a: assert property (!scl_o && !sda_o)
		else $error("pin driven high");
	startup_quiet_a: assert property (up_q < STARTUP_CYCLES |-> !scl_oe && !sda_oe)
		else $error("link active in start-up");
	addr_bits_a: assert property (rise_w && first_q && bit_q < 4'h7
		|-> sda_i == ADDR[3'h6 - bit_q[2:0]]) else $error("bad address bit");
	addr_ack_a: assert property (rise_w && first_q && bit_q == 4'h8 |-> !sda_oe)
		else $error("data held at ack");
endmodule
bind ir_host ir_host_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) ir_host_checker_inst (
	.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// File: ir_array_model.sv
// behavioural infrared array target for the host bench
`timescale 1ns/1ns
module ir_array_model (
	// bus wires, clock made by the host only
	input wire logic scl,
	input wire logic sda,
	output logic pull,
	// test control and observed state
	input wire logic refuse,
	output logic [15:0] cfg_q,
	output logic [15:0] trim_q,
	output int n_meas = 0
);
	logic [7:0] b, op, p0, p1, p2, p3, a, key;
	logic armed_q = 1'h0;
	logic meas_q = 1'h0;
	logic more;
	// byte in, taken while the clock is high
	task automatic rx(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			@(posedge scl);
			v[i] = sda;
		end
	endtask
	// ninth clock: pull low to accept, else wait for the stop
	task automatic ack(input logic ok);
		@(negedge scl);
		pull = ok;
		@(negedge scl);
		pull = 1'h0;
		if (!ok)
			forever @(posedge scl);
	endtask
	// byte out while the clock is low, then the host answer
	task automatic tx(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			pull = !v[i];
			@(negedge scl);
		end
		pull = 1'h0;
		@(posedge scl);
		more = !sda;
		@(negedge scl);
	endtask
	// one session opened by a start
	always @(negedge sda) if (scl) begin : sess
		rx(b);
		ack(b == 8'hC0 && !refuse);
		rx(op);
		ack(1'h1);
		rx(p0);
		ack(1'h1);
		if (op == 8'h01 && p0 == 8'h08 && !meas_q)
			armed_q = 1'h1;
		if (op > 8'h01) begin
			rx(p1);
			ack(1'h1);
			rx(p2);
			ack(1'h1);
		end
		if (op > 8'h02) begin
			rx(p3);
			ack(1'h1);
			key = (op == 8'h03) ? 8'h55 : 8'hAA;
			if (p0 + key == p1 && p2 + key == p3 && op == 8'h03)
				cfg_q = {p3, p1};
			if (p0 + key == p1 && p2 + key == p3 && op == 8'h04)
				trim_q = {p3, p1};
		end
		if (op == 8'h02) begin
			@(negedge sda iff scl);
			rx(b);
			ack(b == 8'hC1);
			a = p0;
			more = 1'h1;
			for (int i = 0; i < p2 && more; i++) begin
				tx(a);
				tx(~a);
				a = a + p1;
			end
		end
	end
	// stop ends the session and starts an armed measurement
	always @(posedge sda) if (scl) begin
		disable sess;
		pull = 1'h0;
		meas_q = meas_q || armed_q;
		n_meas = n_meas + armed_q;
		armed_q = 1'h0;
	end
	// one frame of measuring, then the done flag
	always @(posedge meas_q) begin
		#200000 meas_q = 1'h0;
		cfg_q[9] = 1'h1;
	end
	// bus released at start
	initial pull = 1'h0;
endmodule

// File: ir_host_bench.sv
// self-checking bench of the array host controller
`timescale 1ns/1ns
module ir_host_bench;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} row_t;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, refuse = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, pull, err;
	logic [15:0] cfg_q, trim_q;
	logic [7:0] a;
	int n_meas, miscompares = 0, n_tests = 0;
	row_t rows [8] = '{'{1'h0, 8'h10, 32'h0, 32'h7}, '{1'h0, 8'h04, 32'h0, 32'h0},
		'{1'h1, 8'h10, 32'h9, 32'h7}, '{1'h0, 8'h10, 32'h0, 32'h9},
		'{1'h1, 8'h10, 32'h0, 32'h9}, '{1'h0, 8'h10, 32'h0, 32'h6},
		'{1'h1, 8'h00, 32'h5, 32'h0}, '{1'h0, 8'h08, 32'h0, 32'h10}};
	// open-drain wires with pull-ups
	wire scl = !scl_oe;
	wire sda = !(sda_oe || pull);
	// 25 MHz clock
	always #20 core_clk = !core_clk;
	ir_host #(.STARTUP_CYCLES(20)) ir_host_inst (.core_clk(core_clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	ir_array_model ir_array_model_inst (.scl(scl), .sda(sda), .pull(pull),
		.refuse(refuse), .cfg_q(cfg_q), .trim_q(trim_q), .n_meas(n_meas));
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer, result left in rd and err
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
	endtask
	// poll status until a bit is set
	task automatic wait_stat(input int b);
		rd = 32'h0;
		while (rd[b] !== 1'h1) apb(1'h0, 8'h08, 32'h0);
	endtask
	// verdict
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#3000000;
		miscompares++;
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		apb(1'h1, 8'h00, 32'h1);
		apb(1'h0, 8'h08, 32'h0);
		check(rd, 32'h0);
		repeat (20) @(posedge core_clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			check(rd, rows[i].x);
		end
		apb(1'h0, 8'h14, 32'h0);
		check({31'h0, err}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, 8'h00, 32'h1);
			wait_stat(1);
			check(rd, 32'h12);
		end
		check(n_meas, 32'h1);
		for (int i = 3; i < 5; i++) begin
			apb(1'h1, 8'h04, 32'hBE00 + 32'(i));
			apb(1'h1, 8'h00, 32'(i));
			wait_stat(1);
		end
		check({16'h0, cfg_q}, 32'hBE03);
		check({16'h0, trim_q}, 32'hBE04);
		apb(1'h1, 8'h04, 32'h0304FE);
		apb(1'h1, 8'h00, 32'h2);
		a = 8'hFE;
		for (int i = 0; i < 3; i++) begin
			wait_stat(3);
			apb(1'h0, 8'h0C, 32'h0);
			check(rd, {16'h0, ~a, a});
			a = a + 8'h04;
		end
		wait_stat(1);
		check(rd, 32'h12);
		refuse <= 1'h1;
		apb(1'h1, 8'h00, 32'h1);
		wait_stat(1);
		check(rd, 32'h16);
		end_of_test;
	end
endmodule
